// ### hw/ctp_edge_sync.sv
/*
 * Two-stage synchroniser with edge detection for one input level.
 * Assumes the input may be asynchronous to mclk.
 */
module ctp_edge_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Level in, edge pulses out
    input  wire logic din,
    output logic      rise,
    output logic      fall
);
    import ctp_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ctp_sync_t;

    ctp_sync_t st_reg;
    ctp_sync_t st_next;

    // Shift the level through; only s2 and s3 feed the edge logic.
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Edge pulses last one mclk cycle.
    assign rise = st_reg.s2 & ~st_reg.s3;
    assign fall = ~st_reg.s2 & st_reg.s3;

endmodule : ctp_edge_sync

// ### hw/ctp_tick_gen.sv
/*
 * Count clock tick generator for the compact timer.
 * Assumes the high clock and sub clock are given as one-cycle enables on mclk.
 */
`include "ctp_map.svh"

module ctp_tick_gen (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Source selection and raw enables
    input  wire ctp_pkg::ctp_cksel_t cksel,
    input  wire logic              high_clock_en,
    input  wire logic              sub_clock_en,
    input  wire logic              ext_rise,
    input  wire logic              ext_fall,
    // Selected count tick
    output logic                   tick
);
    import ctp_pkg::*;

    typedef struct packed {
        logic [1:0] div4;
        logic [3:0] div16;
        logic [5:0] div64;
    } ctp_div_t;

    ctp_div_t st_reg;
    ctp_div_t st_next;

    // Free running prescalers for the divided sources.
    always_comb begin
        st_next      = st_reg;
        st_next.div4 = st_reg.div4 + 2'h1;
        if (high_clock_en) begin
            st_next.div16 = st_reg.div16 + 4'h1;
            st_next.div64 = st_reg.div64 + 6'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Pick one tick source per the clock select code.
    always_comb begin
        unique case (cksel)
            CTP_CK_SYS4:  tick = (st_reg.div4 == `CTP_DIV4_LAST);
            CTP_CK_SYS:   tick = 1'b1;
            CTP_CK_HI16:  tick = high_clock_en && (st_reg.div16 == `CTP_DIV16_LAST);
            CTP_CK_HI64:  tick = high_clock_en && (st_reg.div64 == `CTP_DIV64_LAST);
            CTP_CK_SUB_A: tick = sub_clock_en;
            CTP_CK_SUB_B: tick = sub_clock_en;
            CTP_CK_EXT_R: tick = ext_rise;
            CTP_CK_EXT_F: tick = ext_fall;
        endcase
    end

endmodule : ctp_tick_gen

// ### hw/ctp_timer.sv
/*
 * Compact 10-bit timer with compare-match, PWM and timer/counter modes, APB register access.
 * Assumes an APB master on mclk; high and sub clocks arrive as mclk enables.
 */
// What this block does
// R1: Pause bit stops counting, clearing resumes.
// R2: Paused counter holds value, resumes from it.
// R3: Clock select picks one of eight sources.
// R4: Timer-on bit runs or stops counter.
// R5: On rising clears counter; falling holds value.
// R6: On rising restores pin initial level.
// R7: Period value compares counter bits 9..7.
// R8: Clear select picks P or A match.
// R9: Period zero with select zero overflows.
// R10: Clear select ignored in PWM mode.
// R11: Mode field selects compare, PWM or timer.
// R12: Software turns timer off before mode change.
// R13: Timer mode ignores output control bits.
// R14: Compare mode A match: none, low, high, toggle.
// R15: PWM pin function: inactive, active, waveform.
// R16: Requested level equal initial shows no change.
// R17: Software changes pin function only when off.
// R18: Initial level bit sets start or active level.
// R19: Invert bit inverts the output pin.
// R20: Swap bit exchanges PWM period and duty.
// R21: Counter readable as low and high bytes.
// R22: Compare A low byte readable, resets zero.
// R23: Low bytes pass through buffer on high access.
// R24: Duty at or above period gives full duty.
// R25: Only A matches change pin in compare mode.
// R26: External clock pin synchronised before counting.
`include "ctp_map.svh"

module ctp_timer (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Count clock enables and external pin
    input  wire logic        high_clock_en,
    input  wire logic        sub_clock_en,
    input  wire logic        external_count_pin,
    // Timer outputs
    output logic             timer_output_pin,
    output logic             timer_output_pin_inverse,
    output logic             compare_a_flag,
    output logic             compare_p_flag
);
    import ctp_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [9:0]  count;
        logic [9:0]  cmpa;
        logic [7:0]  wbuf;
        logic [7:0]  rbuf;
        logic        on_d;
        logic        pin;
        logic        flag_a;
        logic        flag_p;
        logic [31:0] rdata;
    } ctp_state_t;

    ctp_state_t st_reg;
    ctp_state_t st_next;

    // ------------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------------
    logic       count_pause;
    ctp_cksel_t count_clock_select;
    logic       timer_on;
    logic [2:0] period_compare_value;
    ctp_mode_t  op_mode_select;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_source_select;

    assign count_pause          = st_reg.ctrl0[`CTP_C0_PAUSE];
    assign count_clock_select   = ctp_cksel_t'(st_reg.ctrl0[`CTP_C0_CKSEL_HI:`CTP_C0_CKSEL_LO]);
    assign timer_on             = st_reg.ctrl0[`CTP_C0_ON];
    assign period_compare_value = st_reg.ctrl0[`CTP_C0_PER_HI:`CTP_C0_PER_LO];
    assign op_mode_select       = ctp_mode_t'(st_reg.ctrl1[`CTP_C1_MODE_HI:`CTP_C1_MODE_LO]);
    assign pin_function_select  = st_reg.ctrl1[`CTP_C1_PINF_HI:`CTP_C1_PINF_LO];
    assign output_initial_level = st_reg.ctrl1[`CTP_C1_INIT];
    assign output_invert        = st_reg.ctrl1[`CTP_C1_INV];
    assign duty_period_swap     = st_reg.ctrl1[`CTP_C1_SWAP];
    assign clear_source_select  = st_reg.ctrl1[`CTP_C1_CLRSEL];

    // ------------------------------------------------------------------------
    // Count tick source
    // ------------------------------------------------------------------------
    logic ext_rise;
    logic ext_fall;
    logic tick;

    // The external pin passes a two-flop synchroniser before its edges count.
    ctp_edge_sync u_ext_sync ( // R26
        .mclk (mclk),
        .rst  (rst),
        .din  (external_count_pin),
        .rise (ext_rise),
        .fall (ext_fall)
    );

    // Eight-way clock source selection.
    ctp_tick_gen u_tick ( // R3
        .mclk          (mclk),
        .rst           (rst),
        .cksel         (count_clock_select),
        .high_clock_en (high_clock_en),
        .sub_clock_en  (sub_clock_en),
        .ext_rise      (ext_rise),
        .ext_fall      (ext_fall),
        .tick          (tick)
    );

    // ------------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------------
    // Period value expanded to a full count: zero stands for 1024.
    function automatic logic [10:0] ctp_per_len(input logic [2:0] p);
        ctp_per_len = (p == `CTP_PER_ZERO) ? {1'b1, `CTP_RST_CNT} : {1'b0, p, 7'h00};
    endfunction : ctp_per_len

    // Register map decode shared by read and write paths.
    function automatic logic ctp_hit(input logic [11:0] a, input logic [11:0] off);
        ctp_hit = (a == off);
    endfunction : ctp_hit

    logic        run;
    logic        match_p;
    logic        match_a;
    logic        overflow;
    logic        is_pwm;
    logic [10:0] per_len;
    logic [10:0] pwm_period;
    logic [10:0] pwm_duty;
    logic        pwm_active;
    logic        pwm_clear;

    assign run      = timer_on && !count_pause && tick; // R1 R2 R4
    assign is_pwm   = (op_mode_select == CTP_MODE_PWM);
    assign per_len  = ctp_per_len(period_compare_value);
    // P matches when the top three counter bits reach the period value, on the last clock before it.
    assign match_p  = ({1'b0, st_reg.count} + 11'h001) == per_len; // R7
    assign match_a  = (st_reg.count == st_reg.cmpa) && (st_reg.cmpa != `CTP_RST_CNT);
    assign overflow = (st_reg.count == `CTP_CNT_MAX);

    // Swap bit decides which comparator sets the period.
    assign pwm_period = duty_period_swap ? {1'b0, st_reg.cmpa} : per_len;                   // R20
    assign pwm_duty   = duty_period_swap ? per_len : {1'b0, st_reg.cmpa};                   // R20
    assign pwm_active = (pwm_duty >= pwm_period) || ({1'b0, st_reg.count} < pwm_duty);     // R24
    assign pwm_clear  = duty_period_swap ? match_a : match_p;

    // ------------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------------
    logic        acc;
    logic        wr;
    logic        rd;
    logic        mapped;

    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign mapped = ctp_hit(paddr, `CTP_OFF_CTRL0) || ctp_hit(paddr, `CTP_OFF_CTRL1)
                 || ctp_hit(paddr, `CTP_OFF_CNT_LO) || ctp_hit(paddr, `CTP_OFF_CNT_HI)
                 || ctp_hit(paddr, `CTP_OFF_CMPA_LO) || ctp_hit(paddr, `CTP_OFF_CMPA_HI);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_next        = st_reg;
        st_next.on_d   = timer_on;
        st_next.flag_a = 1'b0;
        st_next.flag_p = 1'b0;

        // Counter advance and clearing.
        if (timer_on && !st_reg.on_d) begin
            st_next.count = `CTP_RST_CNT; // R5
        end else if (run) begin
            if (is_pwm) begin
                st_next.count = pwm_clear ? `CTP_RST_CNT : st_reg.count + `CTP_CNT_ONE; // R10
                st_next.flag_a = match_a;
                st_next.flag_p = match_p;
            end else if (clear_source_select) begin
                // A match clears; P flag is never raised here.
                st_next.count  = (match_a || overflow) ? `CTP_RST_CNT : st_reg.count + `CTP_CNT_ONE; // R8
                st_next.flag_a = match_a;
            end else begin
                // P match clears; period zero means natural overflow.
                st_next.count  = match_p ? `CTP_RST_CNT : st_reg.count + `CTP_CNT_ONE; // R8 R9
                st_next.flag_a = match_a;
                st_next.flag_p = match_p;
            end
        end

        // Output pin level.
        if (timer_on && !st_reg.on_d) begin
            st_next.pin = output_initial_level; // R6
        end else if (op_mode_select == CTP_MODE_CMP && run && match_a) begin // R25
            unique case (pin_function_select) // R14 R16
                2'h0: st_next.pin = st_reg.pin;
                2'h1: st_next.pin = 1'b0;
                2'h2: st_next.pin = 1'b1;
                2'h3: st_next.pin = ~st_reg.pin;
            endcase
        end else if (is_pwm) begin
            unique case (pin_function_select) // R15 R18
                2'h0: st_next.pin = ~output_initial_level;
                2'h1: st_next.pin = output_initial_level;
                2'h2: st_next.pin = pwm_active ? output_initial_level : ~output_initial_level;
                2'h3: st_next.pin = st_reg.pin;
            endcase
        end

        // Register writes; the control bytes and compare A steer logic.
        if (wr) begin
            if (ctp_hit(paddr, `CTP_OFF_CTRL0)) begin
                st_next.ctrl0 = pwdata[7:0];
            end
            if (ctp_hit(paddr, `CTP_OFF_CTRL1)) begin
                st_next.ctrl1 = pwdata[7:0]; // R11
            end
            if (ctp_hit(paddr, `CTP_OFF_CMPA_LO)) begin
                st_next.wbuf = pwdata[7:0]; // R23
            end
            if (ctp_hit(paddr, `CTP_OFF_CMPA_HI)) begin
                st_next.cmpa = {pwdata[1:0], st_reg.wbuf}; // R22 R23
            end
        end

        // Read data capture; high byte reads load the low-byte buffer.
        st_next.rdata = `CTP_ZERO32;
        if (rd) begin
            if (ctp_hit(paddr, `CTP_OFF_CTRL0)) begin
                st_next.rdata = {24'h000000, st_reg.ctrl0};
            end
            if (ctp_hit(paddr, `CTP_OFF_CTRL1)) begin
                st_next.rdata = {24'h000000, st_reg.ctrl1};
            end
            if (ctp_hit(paddr, `CTP_OFF_CNT_HI)) begin
                st_next.rdata = {30'h00000000, st_reg.count[9:8]}; // R21
                st_next.rbuf  = st_reg.count[7:0];                 // R23
            end
            if (ctp_hit(paddr, `CTP_OFF_CMPA_HI)) begin
                st_next.rdata = {30'h00000000, st_reg.cmpa[9:8]};
                st_next.rbuf  = st_reg.cmpa[7:0];                  // R23
            end
            if (ctp_hit(paddr, `CTP_OFF_CNT_LO) || ctp_hit(paddr, `CTP_OFF_CMPA_LO)) begin
                st_next.rdata = {24'h000000, st_reg.rbuf};         // R21 R22
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Read data is combinational from the live registers so it is valid in the access cycle.
    always_comb begin
        prdata = `CTP_ZERO32;
        if (rd) begin
            prdata = st_next.rdata;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Timer mode forces a low pin regardless of output bits.
    logic pin_out;
    assign pin_out = (op_mode_select == CTP_MODE_TMR) ? 1'b0 : (st_reg.pin ^ output_invert); // R13 R19
    assign timer_output_pin         = pin_out;
    assign timer_output_pin_inverse = ~pin_out;
    assign compare_a_flag           = st_reg.flag_a;
    assign compare_p_flag           = st_reg.flag_p;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_on_clears: assert property (@(posedge mclk) disable iff (rst) // R5
        $rose(timer_on) |=> (st_reg.count == `CTP_RST_CNT))
        else $error("counter not cleared on timer-on rise");

    a_pause_holds: assert property (@(posedge mclk) disable iff (rst) // R1
        (count_pause && timer_on && $past(timer_on)) |=> $stable(st_reg.count))
        else $error("counter moved while paused");

    a_off_holds: assert property (@(posedge mclk) disable iff (rst) // R4
        (!timer_on && !$past(timer_on)) |=> $stable(st_reg.count))
        else $error("counter moved while off");

    a_on_init_pin: assert property (@(posedge mclk) disable iff (rst) // R6
        $rose(timer_on) |=> (st_reg.pin == $past(output_initial_level)))
        else $error("pin not set to initial level");

    a_invert_pin: assert property (@(posedge mclk) disable iff (rst) // R19
        (op_mode_select != CTP_MODE_TMR) |-> (timer_output_pin == (st_reg.pin ^ output_invert)))
        else $error("output polarity wrong");

    a_no_p_flag: assert property (@(posedge mclk) disable iff (rst) // R8
        (!is_pwm && clear_source_select && st_reg.ctrl1 == $past(st_reg.ctrl1)) |-> !compare_p_flag)
        else $error("P flag with A clear selected");

    a_p_clear: assert property (@(posedge mclk) disable iff (rst) // R7
        (run && !is_pwm && !clear_source_select && match_p && st_reg.on_d) |=> (st_reg.count == `CTP_RST_CNT))
        else $error("P match did not clear counter");

    a_p_ignores_pin: assert property (@(posedge mclk) disable iff (rst) // R25
        (op_mode_select == CTP_MODE_CMP && st_reg.on_d && timer_on && !(run && match_a)) |=> $stable(st_reg.pin))
        else $error("pin changed without A match");

    a_hi_read_buf: assert property (@(posedge mclk) disable iff (rst) // R23
        (rd && ctp_hit(paddr, `CTP_OFF_CNT_HI)) |=> (st_reg.rbuf == $past(st_reg.count[7:0])))
        else $error("high read did not fill buffer");

endmodule : ctp_timer

// ### include/ctp_map.svh
/*
 * Register offsets, field positions, reset values and timing figures of the compact timer.
 * Assumes inclusion by the design files of the block; definitions only.
 */
`ifndef CTP_MAP_SVH
`define CTP_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB word grid
// ----------------------------------------------------------------------------
`define CTP_OFF_CTRL0      12'h000
`define CTP_OFF_CTRL1      12'h004
`define CTP_OFF_CNT_LO     12'h008
`define CTP_OFF_CNT_HI     12'h00C
`define CTP_OFF_CMPA_LO    12'h010
`define CTP_OFF_CMPA_HI    12'h014

// ----------------------------------------------------------------------------
// Field positions in the control registers
// ----------------------------------------------------------------------------
`define CTP_C0_PAUSE       7
`define CTP_C0_CKSEL_HI    6
`define CTP_C0_CKSEL_LO    4
`define CTP_C0_ON          3
`define CTP_C0_PER_HI      2
`define CTP_C0_PER_LO      0
`define CTP_C1_MODE_HI     7
`define CTP_C1_MODE_LO     6
`define CTP_C1_PINF_HI     5
`define CTP_C1_PINF_LO     4
`define CTP_C1_INIT        3
`define CTP_C1_INV         2
`define CTP_C1_SWAP        1
`define CTP_C1_CLRSEL      0

// ----------------------------------------------------------------------------
// Reset values, widths and counter constants
// ----------------------------------------------------------------------------
`define CTP_RST_BYTE       8'h00
`define CTP_RST_CNT        10'h000
`define CTP_CNT_MAX        10'h3FF
`define CTP_CNT_ONE        10'h001
`define CTP_PER_ZERO       3'h0
`define CTP_CNT_TOP_HI     9
`define CTP_CNT_TOP_LO     7
`define CTP_DIV4_LAST      2'h3
`define CTP_DIV16_LAST     4'hF
`define CTP_DIV64_LAST     6'h3F
`define CTP_ZERO32         32'h00000000

`endif

// ### include/ctp_pkg.sv
/*
 * Types shared by the compact timer design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ctp_pkg;

    // ------------------------------------------------------------------------
    // Operating mode and count clock source codes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTP_MODE_CMP   = 2'h0,
        CTP_MODE_UNDEF = 2'h1,
        CTP_MODE_PWM   = 2'h2,
        CTP_MODE_TMR   = 2'h3
    } ctp_mode_t;

    typedef enum logic [2:0] {
        CTP_CK_SYS4   = 3'h0,
        CTP_CK_SYS    = 3'h1,
        CTP_CK_HI16   = 3'h2,
        CTP_CK_HI64   = 3'h3,
        CTP_CK_SUB_A  = 3'h4,
        CTP_CK_SUB_B  = 3'h5,
        CTP_CK_EXT_R  = 3'h6,
        CTP_CK_EXT_F  = 3'h7
    } ctp_cksel_t;

endpackage : ctp_pkg

// ### verif/tb_ctp_timer.sv
/*
 * Self-checking bench for the compact timer: APB access, counting, pause, compare and PWM pin.
 * Assumes the design files and ctp_map.svh are compiled first; no partner model.
 */
`include "ctp_map.svh"

module tb_ctp_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, pin, pin_n, fa, fp, ext, sub;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  v1, v2;
    int          miscompares, checked, g, k;

    // ------------------------------------------------------------------
    // Design and clock
    // ------------------------------------------------------------------
    ctp_timer i_ctp_timer (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .high_clock_en(1'b0), .sub_clock_en(sub), .external_count_pin(ext),
        .timer_output_pin(pin), .timer_output_pin_inverse(pin_n),
        .compare_a_flag(fa), .compare_p_flag(fp));

    // Free-running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compares one value, counts it and reports a mismatch.
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    // One APB transfer; request held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        check({31'h00000000, pslverr}, {31'h00000000, a == 12'h018});
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Reads a register pair, high byte first so the low byte is latched.
    task automatic rdpair(input logic [11:0] hi, output logic [9:0] v);
        apb(1'b0, hi, 8'h00);
        v[9:8] = r[1:0];
        check(r & 32'hFFFFFFFC, 32'h00000000);
        apb(1'b0, hi - 12'h004, 8'h00);
        v[7:0] = r[7:0];
    endtask : rdpair

    // Cycles from the next compare P pulse to the one after it.
    task automatic p_gap(output int n);
        n = 0;
        do begin @(posedge mclk); n++; end while (fp !== 1'b1 && n < 3000);
        n = 0;
        do begin @(posedge mclk); n++; end while (fp !== 1'b1 && n < 3000);
    endtask : p_gap

    // Counts cycles with the pin high over a span.
    task automatic ones(input int n, output int c);
        c = 0;
        repeat (n) begin @(posedge mclk); c += (pin === 1'b1); end
    endtask : ones

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Cuts a hang short.
    initial begin
        #600000;
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        miscompares = 0; checked = 0;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; ext = 1'b0;
        sub = 1'b0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, `CTP_OFF_CTRL0, 8'h00); check(r, 32'h00000000);
        apb(1'b0, `CTP_OFF_CTRL1, 8'h00); check(r, 32'h00000000);
        rdpair(`CTP_OFF_CMPA_HI, v1); check(v1, 10'h000);
        apb(1'b0, 12'h018, 8'h00); check(r, 32'h00000000);
        // External rising edges in timer mode; output bits must not reach the pin.
        apb(1'b1, `CTP_OFF_CTRL1, 8'hCC);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h68);
        for (int i = 0; i < 8; i++) begin
            if (i == 5) apb(1'b1, `CTP_OFF_CTRL0, 8'h60);
            @(posedge mclk) ext <= 1'b1;
            repeat (4) @(posedge mclk);
            ext <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        rdpair(`CTP_OFF_CNT_HI, v1); check(v1, 10'h005);
        check(pin, 1'b0);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h68);
        rdpair(`CTP_OFF_CNT_HI, v1); check(v1, 10'h000);
        // Sub clock pulses advance the counter one step each.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h48);
        repeat (6) begin
            @(posedge mclk) sub <= 1'b1;
            @(posedge mclk) sub <= 1'b0;
        end
        rdpair(`CTP_OFF_CNT_HI, v1); check(v1, 10'h006);
        // Pause holds the count and counting resumes from it.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h18);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h98);
        rdpair(`CTP_OFF_CNT_HI, v1);
        repeat (20) @(posedge mclk);
        rdpair(`CTP_OFF_CNT_HI, v2); check(v2, v1);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h18);
        rdpair(`CTP_OFF_CNT_HI, v2); check(v2 > v1 && v2 < v1 + 10'd40, 1'b1);
        // Period code 001 on the system clock gives 128 cycles between P matches.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h19);
        p_gap(g); check(g, 128);
        // Compare A through the low byte buffer; a lone low write changes nothing.
        apb(1'b1, `CTP_OFF_CMPA_LO, 8'h32);
        apb(1'b1, `CTP_OFF_CMPA_HI, 8'h00);
        apb(1'b1, `CTP_OFF_CMPA_LO, 8'h77);
        rdpair(`CTP_OFF_CMPA_HI, v1); check(v1, 10'h032);
        apb(1'b1, `CTP_OFF_CMPA_HI, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL1, 8'hC1);
        p_gap(g); check(g, 3000);
        // Compare output, toggle from initial high, then inverted.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL1, 8'h39);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h08);
        repeat (3) @(posedge mclk);
        check(pin, 1'b1);
        g = 0;
        do begin @(posedge mclk); g++; end while (fa !== 1'b1 && g < 1000);
        repeat (2) @(posedge mclk);
        check({pin, pin_n}, 2'b01);
        apb(1'b1, `CTP_OFF_CTRL1, 8'h3D);
        @(posedge mclk);
        check({pin, pin_n}, 2'b10);
        // Drive-high request equal to the initial level leaves the pin alone.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL1, 8'h29);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h08);
        // The pin takes its initial level one cycle after the on bit rises.
        @(posedge mclk);
        ones(1000, k); check(k, 1000);
        // PWM: duty 32 of 128, then duty above the period.
        apb(1'b1, `CTP_OFF_CTRL0, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL1, 8'hA9);
        apb(1'b1, `CTP_OFF_CMPA_LO, 8'h20);
        apb(1'b1, `CTP_OFF_CMPA_HI, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h19);
        // Skip the start-up cycles so the window spans whole periods.
        repeat (2) @(posedge mclk);
        ones(1280, k); check(k, 320);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h00);
        apb(1'b1, `CTP_OFF_CMPA_LO, 8'hC8);
        apb(1'b1, `CTP_OFF_CMPA_HI, 8'h00);
        apb(1'b1, `CTP_OFF_CTRL0, 8'h19);
        ones(300, k); check(k, 300);
        print_verdict();
    end
endmodule : tb_ctp_timer
